// ==== hdl/interval_timer.sv ====
// one-shot interval timer
`timescale 1ns/1ps
`default_nettype none

module interval_timer #(
  parameter int unsigned CYCLES = 1
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // control
  input  wire logic start,
  output logic      done
);

  logic [31:0] cnt_q;
  logic        run_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= 32'h0;
      run_q <= 1'b0;
    end else if (start) begin
      cnt_q <= 32'h0;
      run_q <= 1'b1;
    end else if (run_q) begin
      if (cnt_q == 32'(CYCLES - 1)) begin
        run_q <= 1'b0;
      end else begin
        cnt_q <= cnt_q + 32'h1;
      end
    end
  end

  assign done = run_q && (cnt_q == 32'(CYCLES - 1));

endmodule // interval_timer

`default_nettype wire

// ==== hdl/measurement_mode_control.sv ====
// operating mode sequencer and register map of the acquisition chip
// Function
// R1 - wake-up mode: internal oscillator, one measurement per 1 to 1.5 s, config A
// R2 - before each wake-up measurement power analog ground and reference first
// R3 - wake-up: store result, then power down all but oscillator and divider
// R4 - wake-up: result beyond threshold pulses event pin low one cycle
// R5 - sleep about 1 s after measurement; result stays readable meanwhile
// R6 - serial port works in sleep; host restarts clock before new mode
// R7 - host gives six clock pulses after entering wake-up before stopping clock
// R8 - host sets oversampling ratio 128 in wake-up mode
// R9 - test config writable only in mode 8; host sets it for power-down modes
// R10 - host keeps threshold channel bit cleared for alarm mode
// R11 - alarm mode measures continuously; event pin low one cycle when exceeded
// R12 - negative threshold alarms only when result more negative
// R13 - power-down mode stops acquisition; blocks enabled per configuration
// R14 - internal-clock single equals single, internal clock, sixteen times slower
// R15 - four-bit mode code decode; top bit set means test modes
// R16 - calibration and trim writes accepted only in test modes
// R17 - host never accesses addresses 12 to 15
// R18 - unsupported write may be dropped; device recovers at next start
// R19 - reading calibration or trim disturbs analog; host waits to settle
// R20 - general config 28 bits: sequence, current, voltage, path fields
// R21 - sequence field: count (0 means 16), dechop, chop; resets 1,1,1
// R22 - dual mode alternates A and B, count measurements per config
// R23 - single mode: event pin low as ready flag until host reads
// R24 - threshold compare is signed 16-bit
// R25 - reset to mode 0, load fuses, then accept mode changes
`timescale 1ns/1ps
`default_nettype none
`include "mmc_params.svh"

module measurement_mode_control
  import measurement_mode_pkg::*;
#(
  parameter int unsigned WAKE_CYC = `WAKE_PERIOD_MS * (`CLK_HZ / 1000)
) (
  // clock and reset
  input  wire logic                clk,
  input  wire logic                rst_b,
  // serial port
  input  wire logic                sdi_clk,
  input  wire logic                sdi_en,
  input  wire logic                sdi_din,
  output logic                     sdi_dout,
  output logic                     sdi_dout_oe,
  // fuse storage
  output logic                     fuse_rd_req,
  input  wire logic                fuse_rd_valid,
  input  wire logic [`W_FUSE-1:0]  fuse_rd_data,
  // converter
  output logic                     conv_start,
  input  wire logic                conv_done,
  input  wire logic [15:0]         conv_data,
  input  wire logic                conv_ovf,
  output logic [`W_CFG-1:0]        conv_cfg,
  output logic                     conv_cfg_b,
  // analog control
  output logic                     analog_pwr_on,
  output logic [3:0]               block_en,
  output logic                     int_osc_sel,
  output logic                     analog_read_hit,
  output logic [`W_GEN-1:0]        gen_cfg,
  output logic [`W_CAL-1:0]        cal_word,
  output logic [`W_TRIM-1:0]       trim_word,
  output logic [`W_TEST-1:0]       test_cfg,
  // host event
  output logic                     event_low_pin
);

  // ****************************************************************
  // constants and declarations
  // ****************************************************************
  localparam int unsigned SETTLE_CYC = `SETTLE_US * (`CLK_HZ / 1000000);

  seq_state_t            state_q;
  logic [3:0]            mode_q;
  logic [`W_CFG-1:0]     cfg_a_q, cfg_b_q, conv_cfg_q;
  logic [`W_GEN-1:0]     gen_q;
  logic [`W_RES-1:0]     result_q;
  logic [`W_FUSE-1:0]    fuse_q;
  logic [`W_CAL-1:0]     cal_q;
  logic [`W_TRIM-1:0]    trim_q;
  logic [`W_LIM-1:0]     lim_q;
  logic [`W_TEST-1:0]    test_q;
  logic [3:0]            block_q;
  logic                  busy_q, sel_b_q, event_q, hit_q;
  logic [4:0]            same_cnt_q;
  logic [3:0]            div_q;
  logic                  sclk_prev_q, en_prev_q;
  logic [7:0]            bit_cnt_q;
  logic [4:0]            hdr_q;
  logic [`W_MAX-1:0]     wr_sh_q, rd_sh_q;
  logic                  oe_q;
  logic                  measuring, done_ok, exceed, slow_tick, settle_start, settle_done;
  logic                  wake_start, wake_done, sclk_rise, frame_start, frame_end;
  logic                  hdr_last, wr_commit, res_read;
  logic [3:0]            wr_addr, rd_addr;
  logic [4:0]            seq_len;

  // ****************************************************************
  // mode decode
  // ****************************************************************
  assign measuring = (mode_q == MODE_SINGLE) || (mode_q == MODE_DUAL)   // [R15]
                  || (mode_q == MODE_WAKE_UP) || (mode_q == MODE_ALARM)
                  || (mode_q == MODE_INT_SINGLE);
  assign done_ok   = (state_q == ST_CONV) && busy_q && conv_done;
  assign slow_tick = (div_q == `DIV_LAST);
  // signed compare, direction follows threshold sign
  assign exceed    = lim_q[15] ? ($signed(conv_data) < $signed(lim_q[15:0]))   // [R12] [R24]
                               : ($signed(conv_data) > $signed(lim_q[15:0]));
  assign seq_len   = (gen_q[`SEQ_CNT_MSB:`SEQ_CNT_LSB] == 4'h0) ? `SEQ_FULL    // [R21]
                   : {1'b0, gen_q[`SEQ_CNT_MSB:`SEQ_CNT_LSB]};

  // ****************************************************************
  // timers
  // ****************************************************************
  assign settle_start = ((state_q == ST_IDLE) && measuring)
                     || ((state_q == ST_SLEEP) && (mode_q == MODE_WAKE_UP) && wake_done);
  assign wake_start   = done_ok && (mode_q == MODE_WAKE_UP);

  interval_timer #(.CYCLES(SETTLE_CYC)) u_settle (
    .clk   (clk),
    .rst_b (rst_b),
    .start (settle_start),
    .done  (settle_done)
  );

  interval_timer #(.CYCLES(WAKE_CYC)) u_wake (
    .clk   (clk),
    .rst_b (rst_b),
    .start (wake_start),
    .done  (wake_done)
  );

  // ****************************************************************
  // sequencer
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= ST_FUSE;
    end else begin
      unique case (state_q)
        ST_FUSE: begin
          if (fuse_rd_valid) state_q <= ST_IDLE;   // [R25]
        end
        ST_IDLE: begin
          if (measuring) state_q <= ST_POWER;
        end
        ST_POWER: begin
          if (!measuring) state_q <= ST_IDLE;
          else if (settle_done) state_q <= ST_CONV;   // [R2]
        end
        ST_CONV: begin
          if (!measuring) state_q <= ST_IDLE;   // [R13]
          else if (wake_start) state_q <= ST_SLEEP;   // [R3]
        end
        ST_SLEEP: begin
          if (mode_q != MODE_WAKE_UP) state_q <= ST_IDLE;   // [R6]
          else if (wake_done) state_q <= ST_POWER;   // [R1] [R5]
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  assign fuse_rd_req   = (state_q == ST_FUSE);
  assign analog_pwr_on = (state_q == ST_POWER) || (state_q == ST_CONV);   // [R2] [R3]
  assign conv_start    = (state_q == ST_CONV) && !busy_q && measuring   // [R14]
                      && ((mode_q != MODE_INT_SINGLE) || slow_tick);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      busy_q <= 1'b0;
    end else if (conv_start) begin
      busy_q <= 1'b1;
    end else if (done_ok || (state_q != ST_CONV) || !measuring) begin
      busy_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      div_q <= 4'h0;
    end else begin
      div_q <= div_q + 4'h1;   // [R14]
    end
  end

  // dual mode alternation
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sel_b_q    <= 1'b0;
      same_cnt_q <= 5'h0;
    end else if (mode_q != MODE_DUAL) begin
      sel_b_q    <= 1'b0;   // [R1]
      same_cnt_q <= 5'h0;
    end else if (done_ok) begin
      if (same_cnt_q + 5'h1 >= seq_len) begin
        sel_b_q    <= !sel_b_q;   // [R22]
        same_cnt_q <= 5'h0;
      end else begin
        same_cnt_q <= same_cnt_q + 5'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      conv_cfg_q <= '0;
    end else begin
      conv_cfg_q <= sel_b_q ? cfg_b_q : cfg_a_q;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      result_q <= '0;
    end else if (done_ok) begin
      result_q <= {conv_ovf, sel_b_q, conv_data};   // [R3]
    end
  end

  // ****************************************************************
  // event pin
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      event_q <= 1'b1;
    end else if (done_ok && ((mode_q == MODE_WAKE_UP) || (mode_q == MODE_ALARM))) begin
      event_q <= !exceed;   // [R4] [R11]
    end else if (done_ok && ((mode_q == MODE_SINGLE) || (mode_q == MODE_INT_SINGLE))) begin
      event_q <= 1'b0;   // [R23]
    end else if (res_read || ((mode_q != MODE_SINGLE) && (mode_q != MODE_INT_SINGLE))) begin
      event_q <= 1'b1;
    end
  end

  // ****************************************************************
  // analog block enables
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      block_q <= `BLK_ALL_ON;
    end else if (mode_q == MODE_POWER_DOWN) begin
      block_q <= gen_q[3:0];   // [R13]
    end else begin
      block_q <= `BLK_ALL_ON;
    end
  end

  // ****************************************************************
  // serial port
  // ****************************************************************
  assign sclk_rise   = sdi_clk && !sclk_prev_q && sdi_en;
  assign frame_start = sdi_en && !en_prev_q;
  assign frame_end   = !sdi_en && en_prev_q;
  assign hdr_last    = sclk_rise && (bit_cnt_q == `HDR_BITS - 8'h1);
  assign rd_addr     = {hdr_q[2:0], sdi_din};
  assign wr_addr     = hdr_q[3:0];
  assign res_read    = hdr_last && hdr_q[3] && (rd_addr == `ADDR_RESULT);
  // a write counts only when exactly header plus register width was clocked
  assign wr_commit   = frame_end && !hdr_q[4] && (state_q != ST_FUSE)   // [R18]
                    && (bit_cnt_q == `HDR_BITS + reg_width(wr_addr));

  function automatic logic [7:0] reg_width(input logic [3:0] a);
    logic [7:0] w;
    w = 8'h0;
    unique case (a)
      `ADDR_MODE:   w = 8'(`W_MODE);
      `ADDR_CFG_A:  w = 8'(`W_CFG);
      `ADDR_CFG_B:  w = 8'(`W_CFG);
      `ADDR_GEN:    w = 8'(`W_GEN);
      `ADDR_RESULT: w = 8'(`W_RES);
      `ADDR_FUSE:   w = 8'(`W_FUSE);
      `ADDR_CAL:    w = 8'(`W_CAL);
      `ADDR_TRIM:   w = 8'(`W_TRIM);
      `ADDR_LIMIT:  w = 8'(`W_LIM);
      `ADDR_TEST:   w = 8'(`W_TEST);
      default:      w = 8'h0;
    endcase
    return w;
  endfunction

  // read data left aligned so the first bit out is the register msb
  function automatic logic [`W_MAX-1:0] rd_value(input logic [3:0] a);
    logic [`W_MAX-1:0] v;
    v = '0;
    unique case (a)
      `ADDR_MODE:   v = {mode_q,   {(`W_MAX-`W_MODE){1'b0}}};
      `ADDR_CFG_A:  v = {cfg_a_q,  {(`W_MAX-`W_CFG){1'b0}}};
      `ADDR_CFG_B:  v = {cfg_b_q,  {(`W_MAX-`W_CFG){1'b0}}};
      `ADDR_GEN:    v = {gen_q,    {(`W_MAX-`W_GEN){1'b0}}};
      `ADDR_RESULT: v = {result_q, {(`W_MAX-`W_RES){1'b0}}};   // [R5]
      `ADDR_FUSE:   v = fuse_q;
      `ADDR_CAL:    v = {cal_q,    {(`W_MAX-`W_CAL){1'b0}}};
      `ADDR_TRIM:   v = {trim_q,   {(`W_MAX-`W_TRIM){1'b0}}};
      `ADDR_LIMIT:  v = {lim_q,    {(`W_MAX-`W_LIM){1'b0}}};
      `ADDR_TEST:   v = {test_q,   {(`W_MAX-`W_TEST){1'b0}}};
      default:      v = '0;
    endcase
    return v;
  endfunction

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sclk_prev_q <= 1'b0;
      en_prev_q   <= 1'b0;
      bit_cnt_q   <= 8'h0;
      hdr_q       <= 5'h0;
      wr_sh_q     <= '0;
      rd_sh_q     <= '0;
      oe_q        <= 1'b0;
    end else begin
      sclk_prev_q <= sdi_clk;
      en_prev_q   <= sdi_en;
      if (frame_start || frame_end) begin
        bit_cnt_q <= 8'h0;   // [R6] [R18]
        oe_q      <= 1'b0;
      end else if (sclk_rise) begin
        if (bit_cnt_q != `CNT_SAT) bit_cnt_q <= bit_cnt_q + 8'h1;
        if (bit_cnt_q < `HDR_BITS) begin
          hdr_q <= {hdr_q[3:0], sdi_din};
        end else if (!hdr_q[4]) begin
          wr_sh_q <= {wr_sh_q[`W_MAX-2:0], sdi_din};
        end else begin
          rd_sh_q <= {rd_sh_q[`W_MAX-2:0], 1'b0};
        end
        if (hdr_last && hdr_q[3]) begin
          rd_sh_q <= rd_value(rd_addr);
          oe_q    <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hit_q <= 1'b0;
    end else begin
      hit_q <= hdr_last && hdr_q[3]   // [R19]
            && ((rd_addr == `ADDR_CAL) || (rd_addr == `ADDR_TRIM));
    end
  end

  // ****************************************************************
  // register writes
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_q <= MODE_FUSE_LOAD;   // [R25]
    end else if (wr_commit && (wr_addr == `ADDR_MODE)) begin
      mode_q <= wr_sh_q[`W_MODE-1:0];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_a_q <= '0;
      cfg_b_q <= '0;
      gen_q   <= `GEN_RESET;   // [R20] [R21]
      lim_q   <= '0;
    end else if (wr_commit) begin
      if (wr_addr == `ADDR_CFG_A) cfg_a_q <= wr_sh_q[`W_CFG-1:0];
      if (wr_addr == `ADDR_CFG_B) cfg_b_q <= wr_sh_q[`W_CFG-1:0];
      if (wr_addr == `ADDR_GEN)   gen_q   <= wr_sh_q[`W_GEN-1:0];
      if (wr_addr == `ADDR_LIMIT) lim_q   <= wr_sh_q[`W_LIM-1:0];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fuse_q <= '0;
      cal_q  <= '0;
      trim_q <= '0;
    end else if ((state_q == ST_FUSE) && fuse_rd_valid) begin
      fuse_q <= fuse_rd_data;   // [R25]
      cal_q  <= fuse_rd_data[`W_CAL-1:0];
      trim_q <= fuse_rd_data[`W_CAL+`W_TRIM-1:`W_CAL];
    end else if (wr_commit) begin
      if ((wr_addr == `ADDR_FUSE) && (mode_q == MODE_FUSE_PROG)) fuse_q <= wr_sh_q;
      if ((wr_addr == `ADDR_CAL) && mode_q[3]) cal_q <= wr_sh_q[`W_CAL-1:0];   // [R16]
      if ((wr_addr == `ADDR_TRIM) && mode_q[3]) trim_q <= wr_sh_q[`W_TRIM-1:0];   // [R16]
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      test_q <= `TEST_RESET;
    end else if (wr_commit && (wr_addr == `ADDR_TEST) && (mode_q == MODE_TEST_FIRST)) begin
      test_q <= wr_sh_q[`W_TEST-1:0];   // [R9]
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign sdi_dout        = rd_sh_q[`W_MAX-1];
  assign sdi_dout_oe     = oe_q;
  assign conv_cfg        = conv_cfg_q;
  assign conv_cfg_b      = sel_b_q;
  assign block_en        = block_q;
  assign int_osc_sel     = (mode_q == MODE_WAKE_UP) || (mode_q == MODE_INT_SINGLE);   // [R1] [R14]
  assign analog_read_hit = hit_q;
  assign gen_cfg         = gen_q;
  assign cal_word        = cal_q;
  assign trim_word       = trim_q;
  assign test_cfg        = test_q;
  assign event_low_pin   = event_q;

  // ****************************************************************
  // assertions
  // ****************************************************************
  a_event_one_cycle: assert property (@(posedge clk) disable iff (!rst_b)   // [R4] [R11]
    (!event_low_pin && ((mode_q == MODE_WAKE_UP) || (mode_q == MODE_ALARM))
     && $stable(mode_q)) |=> event_low_pin)
    else $error("event pulse longer than one cycle");

  a_sleep_power_off: assert property (@(posedge clk) disable iff (!rst_b)   // [R3]
    (state_q == ST_SLEEP) |-> !analog_pwr_on && !conv_start)
    else $error("analog powered during sleep");

  a_conv_after_power: assert property (@(posedge clk) disable iff (!rst_b)   // [R2]
    $rose(state_q == ST_CONV) |-> $past(settle_done) && analog_pwr_on)
    else $error("conversion started without settling");

  a_reset_mode_zero: assert property (@(posedge clk) disable iff (!rst_b)   // [R25]
    (state_q == ST_FUSE) |-> (mode_q == MODE_FUSE_LOAD) && (gen_q[`SEQ_FLD_MSB:`SEQ_FLD_LSB] == `SEQ_RESET))
    else $error("mode or sequence field changed before fuse load");

  a_test_write_lock: assert property (@(posedge clk) disable iff (!rst_b)   // [R9]
    (mode_q != MODE_TEST_FIRST) |=> $stable(test_q))
    else $error("test config written outside mode 8");

  a_cal_write_lock: assert property (@(posedge clk) disable iff (!rst_b)   // [R16]
    (!mode_q[3] && (state_q != ST_FUSE)) |=> $stable(cal_q) && $stable(trim_q))
    else $error("calibration or trim written outside test mode");

  a_pd_no_conv: assert property (@(posedge clk) disable iff (!rst_b)   // [R13]
    (mode_q == MODE_POWER_DOWN) |-> !conv_start
      && (($past(mode_q) != MODE_POWER_DOWN) || !busy_q))
    else $error("acquisition running in power down");

  a_result_load: assert property (@(posedge clk) disable iff (!rst_b)   // [R3]
    done_ok |=> (result_q[15:0] == $past(conv_data)) && (result_q[`RES_CHAN_BIT] == $past(sel_b_q)))
    else $error("result not stored after conversion");

  a_int_slow_rate: assert property (@(posedge clk) disable iff (!rst_b)   // [R14]
    (conv_start && (mode_q == MODE_INT_SINGLE)) |-> slow_tick)
    else $error("internal clock conversion off the slow tick");

  a_wake_sleep_hold: assert property (@(posedge clk) disable iff (!rst_b)   // [R5]
    (state_q == ST_SLEEP) && (mode_q == MODE_WAKE_UP) && !wake_done |=> (state_q == ST_SLEEP))
    else $error("sleep left before wake period");

endmodule // measurement_mode_control

`default_nettype wire

// ==== hdl/measurement_mode_pkg.sv ====
// types for the measurement mode controller
package measurement_mode_pkg;

  typedef enum logic [3:0] {
    MODE_FUSE_LOAD   = 4'h0,
    MODE_SINGLE      = 4'h1,
    MODE_DUAL        = 4'h2,
    MODE_WAKE_UP     = 4'h3,
    MODE_ALARM       = 4'h4,
    MODE_FUSE_PROG   = 4'h5,
    MODE_POWER_DOWN  = 4'h6,
    MODE_INT_SINGLE  = 4'h7,
    MODE_TEST_FIRST  = 4'h8
  } mode_t;

  typedef enum logic [2:0] {
    ST_FUSE  = 3'b000,
    ST_IDLE  = 3'b001,
    ST_POWER = 3'b010,
    ST_CONV  = 3'b011,
    ST_SLEEP = 3'b100
  } seq_state_t;

endpackage

// ==== hdl/mmc_params.svh ====
// constants for the measurement mode controller
`ifndef MMC_PARAMS_SVH
`define MMC_PARAMS_SVH

// ****************************************************************
// register addresses
// ****************************************************************
`define ADDR_MODE    4'h0
`define ADDR_CFG_A   4'h1
`define ADDR_CFG_B   4'h2
`define ADDR_GEN     4'h3
`define ADDR_RESULT  4'h4
`define ADDR_FUSE    4'h5
`define ADDR_CAL     4'h6
`define ADDR_TRIM    4'h7
`define ADDR_LIMIT   4'h8
`define ADDR_TEST    4'h9

// ****************************************************************
// register widths
// ****************************************************************
`define W_MODE   4
`define W_CFG    17
`define W_GEN    28
`define W_RES    18
`define W_FUSE   188
`define W_CAL    110
`define W_TRIM   20
`define W_LIM    17
`define W_TEST   20
`define W_MAX    188
`define HDR_BITS 8'h05
`define CNT_SAT  8'hFF

// ****************************************************************
// field positions and reset values
// ****************************************************************
`define SEQ_CNT_MSB  27
`define SEQ_CNT_LSB  24
`define SEQ_FLD_MSB  27
`define SEQ_FLD_LSB  22
`define SEQ_RESET    6'h07
`define GEN_RESET    28'h1C00000
`define LIM_CHAN_BIT 16
`define RES_CHAN_BIT 16
`define RES_OVF_BIT  17
`define TEST_RESET   20'h00000
`define SEQ_FULL     5'h10
`define BLK_ALL_ON   4'hF
`define DIV_LAST     4'hF

// ****************************************************************
// timing
// ****************************************************************
`define CLK_HZ         125000000
`define WAKE_PERIOD_MS 1000
`define SETTLE_US      10
`define INT_SLOW_DIV   16

`endif

// ==== verification/host_model.sv ====
// serial host model for the measurement mode controller
`timescale 1ns/1ps
`default_nettype none
module host_model (
  // clock
  input  wire logic clk,
  // serial port
  output logic      sdi_clk,
  output logic      sdi_en,
  output logic      sdi_din,
  input  wire logic sdi_dout
);
  initial begin
    sdi_clk = 1'b0;
    sdi_en  = 1'b0;
    sdi_din = 1'b0;
  end
  // one bit: clock low two cycles, then high two cycles
  task automatic put_bit(input logic b);
    sdi_din = b;
    repeat (2) @(posedge clk);
    #1 sdi_clk = 1'b1;
    repeat (2) @(posedge clk);
    #1 sdi_clk = 1'b0;
  endtask
  // whole frame: rw, address msb first, exactly n data bits
  task automatic frame(input logic rw, input logic [3:0] a, input int n,
                       input logic [187:0] d, output logic [187:0] q);
    q = '0;
    sdi_en = 1'b1;
    put_bit(rw);
    for (int i = 3; i >= 0; i--) put_bit(a[i]);
    for (int i = n - 1; i >= 0; i--) begin
      q[i] = sdi_dout;
      put_bit(d[i]);
    end
    @(posedge clk);
    #1 sdi_en = 1'b0;
    sdi_din = ~sdi_din;
    @(posedge clk);
    #1;
  endtask
endmodule // host_model
`default_nettype wire

// ==== verification/test_measurement_mode_control.sv ====
// self-checking bench for the measurement mode controller
`timescale 1ns/1ps
`default_nettype none
module test_measurement_mode_control;
  logic          clk, rst_b, sdi_clk, sdi_en, sdi_din, sdi_dout, fuse_rd_req;
  logic          fuse_rd_valid, conv_start, conv_done, conv_ovf, analog_pwr_on;
  logic          int_osc_sel, event_low_pin;
  logic [187:0]  fuse_rd_data, q;
  logic [15:0]   conv_data, cval;
  logic [109:0]  cal_word;
  logic [19:0]   trim_word, test_cfg;
  logic [3:0]    block_en;
  logic [27:0]   gen_cfg;
  int            err_total, total_checks, ev_cnt, dn_cnt, cyc, e0, d0;

  host_model host (.clk(clk), .sdi_clk(sdi_clk), .sdi_en(sdi_en), .sdi_din(sdi_din),
    .sdi_dout(sdi_dout));
  measurement_mode_control #(.WAKE_CYC(200)) uut (.clk(clk), .rst_b(rst_b),
    .sdi_clk(sdi_clk), .sdi_en(sdi_en), .sdi_din(sdi_din), .sdi_dout(sdi_dout),
    .sdi_dout_oe(), .fuse_rd_req(fuse_rd_req), .fuse_rd_valid(fuse_rd_valid),
    .fuse_rd_data(fuse_rd_data), .conv_start(conv_start), .conv_done(conv_done),
    .conv_data(conv_data), .conv_ovf(conv_ovf), .conv_cfg(), .conv_cfg_b(),
    .analog_pwr_on(analog_pwr_on), .block_en(block_en), .int_osc_sel(int_osc_sel),
    .analog_read_hit(), .gen_cfg(gen_cfg), .cal_word(cal_word),
    .trim_word(trim_word), .test_cfg(test_cfg), .event_low_pin(event_low_pin));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // converter model: answers each start three cycles later
  always @(posedge clk) begin
    #1;
    if (conv_done === 1'b1) begin
      conv_done = 1'b0;
      conv_data = ~cval;
    end
    if (conv_start === 1'b1) begin
      repeat (3) @(posedge clk);
      #1 conv_data = cval;
      conv_done = 1'b1;
      dn_cnt++;
    end
  end
  always @(posedge clk) begin
    #1;
    if (event_low_pin === 1'b0) ev_cnt++;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      $display("ERROR %0t timeout", $time);
      print_verdict();
    end
  end
  task automatic chk(input logic c);
    total_checks++;
    if (c !== 1'b1) begin
      err_total++;
      $display("ERROR %0t mismatch", $time);
    end
  endtask
  task automatic wr(input logic [3:0] a, input int n, input logic [187:0] d);
    host.frame(1'b0, a, n, d, q);
  endtask
  // event pulses versus conversions over a window
  task automatic win(input logic hit);
    repeat (10) @(posedge clk);
    e0 = ev_cnt;
    d0 = dn_cnt;
    repeat (40) @(posedge clk);
    chk(dn_cnt > d0 && (ev_cnt - e0) == (hit ? dn_cnt - d0 : 0));
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_fuse();
    wr(4'h0, 4, 188'h1);
    host.frame(1'b1, 4'h0, 4, '0, q);
    chk(q[3:0] === 4'h0 && fuse_rd_req === 1'b1);
    fuse_rd_valid = 1'b1;
    @(posedge clk);
    #1 fuse_rd_valid = 1'b0;
    @(posedge clk);
    #1;
    chk(cal_word === fuse_rd_data[109:0] && trim_word === 20'hAAAAA);
    host.frame(1'b1, 4'h3, 28, '0, q);
    chk(q[27:0] === 28'h1C00000 && gen_cfg === 28'h1C00000);
  endtask
  task automatic t_alarm();
    wr(4'h8, 17, 188'h00064);
    wr(4'h0, 4, 188'h4);
    repeat (1260) @(posedge clk);
    cval = 16'd200;
    win(1'b1);
    cval = 16'd50;
    win(1'b0);
    wr(4'h8, 17, 188'h0FF9C);
    cval = 16'hFFCE;
    win(1'b0);
    cval = 16'hFF38;
    win(1'b1);
    wr(4'h7, 20, 188'h12345);
    chk(trim_word === 20'hAAAAA);
  endtask
  task automatic t_wake();
    wr(4'h8, 17, 188'h00064);
    cval = 16'd50;
    wr(4'h0, 4, 188'h6);
    repeat (10) @(posedge clk);
    d0 = dn_cnt;
    chk(analog_pwr_on === 1'b0 && block_en === 4'h0);
    wr(4'h0, 4, 188'h3);
    cval = 16'd300;
    repeat (6) @(posedge clk);
    e0 = ev_cnt;
    chk(int_osc_sel === 1'b1 && analog_pwr_on === 1'b1 && dn_cnt == d0);
    for (int k = 0; k < 1400 && dn_cnt == d0; k++) @(posedge clk);
    repeat (3) @(posedge clk);
    chk(dn_cnt == d0 + 1 && analog_pwr_on === 1'b0 && ev_cnt == e0 + 1);
    host.frame(1'b1, 4'h4, 18, '0, q);
    chk(q[17:0] === 18'd300 && analog_pwr_on === 1'b0);
    wr(4'h0, 4, 188'h8);
    wr(4'h9, 20, 188'h3);
    chk(test_cfg === 20'h00003);
    wr(4'h7, 20, 188'h12345);
    chk(trim_word === 20'h12345);
  endtask
  task automatic print_verdict();
    if (err_total == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    rst_b = 1'b0;
    fuse_rd_valid = 1'b0;
    fuse_rd_data = {94{2'b10}};
    conv_done = 1'b0;
    conv_ovf = 1'b0;
    conv_data = 16'h0000;
    cval = 16'h0000;
    repeat (20) @(posedge clk);
    #1 rst_b = 1'b1;
    t_fuse();
    t_alarm();
    t_wake();
    print_verdict();
  end
endmodule // test_measurement_mode_control
`default_nettype wire
